// >>> rtl/scp_config_port.sv
`timescale 1ns/1ps
`default_nettype none
module scp_config_port
   import scp_pkg::*;
#(
   parameter int unsigned NVM_WRITE_CYCLES = NVM_WRITE_CYCLES_DEF,
   parameter logic [7:0] IDENT_BYTE = 8'h005a // arbitrary value
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clk_link,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic scl_in,
   input wire logic first_select_pin,
   input wire logic output_supply_rail_grounded,
   output logic [2:0] active_slot,
   output logic first_output_state_select,
   output logic frequency_slot_select,
   output logic [2:0] spread_amount_select,
   output logic pll_output_pair_state_select,
   output logic device_power_down,
   output logic nvm_programming_busy_flag,
   output logic serial_port_active
);
   localparam int CNT_W = $clog2(NVM_WRITE_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(NVM_WRITE_CYCLES - 1);

   logic [1:0] lrst_q;
   logic sda_low, req_tgl;
   scp_req_type req_kind;
   logic [6:0] req_off;
   logic [7:0] req_data;
   logic [1:0] req_s_q;
   logic req_seen_q, rsp_ok_q, rsp_ok_d;
   logic [7:0] rsp_data_q, rsp_data_d;
   logic [3:0] pin_s1_q, pin_s2_q;
   logic [7:0] cfg_q [REG_BYTES];
   logic busy_q, nvm_pin_func_q, serial_q;
   logic [CNT_W-1:0] nvm_cnt_q;
   logic [2:0] slot_q;
   logic take, in_map, wr_take, addr_hit;
   logic [4:0] idx;

   // ----------------------------------------
   // link side
   // ----------------------------------------
   // reset released into the link domain
   always_ff @(posedge clk_link) begin
      lrst_q <= {lrst_q[0], reset_n};
   end

   scp_link_engine u_link (
      .clk_link(clk_link),
      .rst_link_n(lrst_q[1]),
      .scl_pin(scl_in),
      .sda_pin(sda_in),
      .ack_tgl(req_seen_q),
      .rsp_ok(rsp_ok_q),
      .rsp_data(rsp_data_q),
      .sda_low(sda_low),
      .req_tgl(req_tgl),
      .req_kind(req_kind),
      .req_off(req_off),
      .req_data(req_data)
   );

   // open drain: only ever pulls low
   assign sda_out = 1'b0;
   assign sda_oe = sda_low;

   // ----------------------------------------
   // crossing into the system domain
   // ----------------------------------------
   // request toggle sync; held fields read only on take
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         req_s_q <= 2'h0;
      end else begin
         req_s_q <= {req_s_q[0], req_tgl};
      end
   end

   assign take = req_s_q[1] != req_seen_q;
   assign in_map = req_off < 7'(REG_BYTES);
   assign idx = req_off[4:0];
   assign wr_take = take && req_kind == REQ_WRITE && serial_q && !busy_q;
   assign addr_hit = serial_q &&
      req_data[7:1] == {ADDR_FIXED, cfg_q[IDX_DEV_CTRL][1:0]};

   // ----------------------------------------
   // register read view
   // ----------------------------------------
   function automatic logic [7:0] read_byte(input logic [4:0] i);
      unique case (i)
         IDX_IDENT: read_byte = IDENT_BYTE;
         IDX_DEV_CTRL: read_byte = {1'b0, busy_q, cfg_q[i][5:0]};
         default: read_byte = cfg_q[i];
      endcase
   endfunction

   // bits that software may store per byte
   function automatic logic [7:0] write_mask(input logic [4:0] i);
      unique case (i)
         IDX_IDENT: write_mask = 8'h00;
         IDX_DEV_CTRL: write_mask = DEV_CTRL_MASK;
         IDX_BLK_CTRL: write_mask = BLK_CTRL_MASK;
         default: write_mask = 8'hff;
      endcase
   endfunction

   // answer to one request
   always_comb begin
      rsp_ok_d = 1'b0;
      rsp_data_d = 8'h00;
      unique case (req_kind)
         REQ_ADDR: rsp_ok_d = addr_hit;
         REQ_WRITE: rsp_ok_d = serial_q && !busy_q;
         REQ_RD_ONE: rsp_ok_d = req_data == 8'h00;
         REQ_RD_BLK: rsp_ok_d =
            req_data < {3'h0, cfg_q[IDX_BLK_CTRL][7:3]};
      endcase
      if (in_map) begin
         rsp_data_d = read_byte(idx);
      end
   end

   // answer flops and acknowledge toggle
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         req_seen_q <= 1'b0;
         rsp_ok_q <= 1'b0;
         rsp_data_q <= 8'h00;
      end else if (take) begin
         req_seen_q <= req_s_q[1];
         rsp_ok_q <= rsp_ok_d;
         rsp_data_q <= rsp_data_d;
      end
   end

   // ----------------------------------------
   // register file
   // ----------------------------------------
   // factory image at power-up, byte writes land at once
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         for (int i = 0; i < REG_BYTES; i++) begin
            cfg_q[i] <= scp_reset_byte(5'(i));
         end
      end else if (wr_take && in_map) begin
         cfg_q[idx] <= req_data & write_mask(idx);
      end
   end

   // ----------------------------------------
   // nonvolatile commit cycle
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         busy_q <= 1'b0;
         nvm_cnt_q <= '0;
         nvm_pin_func_q <= 1'b0;
      end else if (busy_q) begin
         if (nvm_cnt_q == CNT_LAST) begin
            busy_q <= 1'b0;
            nvm_pin_func_q <= cfg_q[IDX_PIN_CFG][BIT_PIN_FUNC];
         end else begin
            nvm_cnt_q <= nvm_cnt_q + 1'b1;
         end
      end else if (wr_take && in_map && idx == IDX_BLK_CTRL &&
                   req_data[BIT_NVM_GO]) begin
         busy_q <= 1'b1;
         nvm_cnt_q <= '0;
      end
   end

   // ----------------------------------------
   // pins and setting selection
   // ----------------------------------------
   // two-stage sync: rail, clock pin, data pin, first select
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         pin_s1_q <= 4'h0;
         pin_s2_q <= 4'h0;
      end else begin
         pin_s1_q <= {output_supply_rail_grounded, scl_in, sda_in,
                      first_select_pin};
         pin_s2_q <= pin_s1_q;
      end
   end

   // pin role and active slot
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         serial_q <= 1'b1;
         slot_q <= 3'h0;
      end else begin
         serial_q <= ~nvm_pin_func_q | pin_s2_q[3];
         slot_q[0] <= pin_s2_q[0];
         slot_q[1] <= serial_q ? 1'b0 : pin_s2_q[1];
         slot_q[2] <= serial_q ? 1'b0 : pin_s2_q[2];
      end
   end

   // per-slot fields of the active setting, plus the power-down bit
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         first_output_state_select <= 1'b0;
         frequency_slot_select <= 1'b0;
         spread_amount_select <= 3'h0;
         pll_output_pair_state_select <= 1'b0;
         device_power_down <= 1'b0;
      end else begin
         first_output_state_select <= cfg_q[IDX_Y1_SLOTS][slot_q];
         frequency_slot_select <= cfg_q[IDX_FREQ_SLOTS][slot_q];
         spread_amount_select <= {cfg_q[IDX_SPREAD_HI][slot_q],
                                  cfg_q[IDX_SPREAD_MID][slot_q],
                                  cfg_q[IDX_SPREAD_LO][slot_q]};
         pll_output_pair_state_select <= cfg_q[IDX_PAIR_SLOTS][slot_q];
         device_power_down <= cfg_q[IDX_DEV_CTRL][BIT_POWER_DOWN];
      end
   end

   assign active_slot = slot_q;
   assign nvm_programming_busy_flag = busy_q;
   assign serial_port_active = serial_q;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb_sys @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);

   a_busy_refuses_write: assert property (
      take && req_kind == REQ_WRITE && busy_q |=> !rsp_ok_q
   ) else $error("write accepted during nvm cycle");

   a_busy_serves_read: assert property (
      take && req_kind == REQ_RD_ONE && req_data == 8'h00 && busy_q
      |=> rsp_ok_q
   ) else $error("read refused during nvm cycle");

   a_addr_match_ack: assert property (
      take && req_kind == REQ_ADDR && addr_hit |=> rsp_ok_q
   ) else $error("own address not acknowledged");

   a_addr_miss_nack: assert property (
      take && req_kind == REQ_ADDR && req_data[7:3] != ADDR_FIXED
      |=> !rsp_ok_q
   ) else $error("foreign address acknowledged");

   a_ctrl_mode_mute: assert property (
      take && req_kind == REQ_ADDR && !serial_q |=> !rsp_ok_q
   ) else $error("slave answered in control mode");

   a_serial_slot_low: assert property (
      serial_q && $past(serial_q) |-> active_slot[2:1] == 2'h0
   ) else $error("upper select bits used in serial mode");

   a_write_takes_effect: assert property (
      wr_take && idx == IDX_Y1_SLOTS && in_map
      |=> cfg_q[IDX_Y1_SLOTS] == $past(req_data) ##1
          first_output_state_select == cfg_q[IDX_Y1_SLOTS][$past(slot_q)]
   ) else $error("written byte not effective");

   a_pin_func_commit: assert property (
      $changed(nvm_pin_func_q) |-> $past(busy_q) && !busy_q
   ) else $error("pin role changed outside commit");

   a_block_read_len: assert property (
      take && req_kind == REQ_RD_BLK &&
      req_data >= {3'h0, cfg_q[IDX_BLK_CTRL][7:3]} |=> !rsp_ok_q
   ) else $error("block read past byte count");

   a_power_down: assert property (
      cfg_q[IDX_DEV_CTRL][BIT_POWER_DOWN] |=> device_power_down
   ) else $error("power-down bit not applied");

   a_busy_length: assert property (
      $fell(busy_q) |-> $past(nvm_cnt_q) == CNT_LAST
   ) else $error("nvm cycle length wrong");

   a_ident_readonly: assert property (
      wr_take && idx == IDX_IDENT |=> read_byte(IDX_IDENT) == IDENT_BYTE
   ) else $error("identity byte overwritten");

   c_block_write: cover property (
      wr_take && $past(wr_take, 1) == 1'b0 ##[1:900] wr_take
   );
   c_read_busy: cover property (
      take && req_kind == REQ_RD_BLK && busy_q
   );
   c_ctrl_mode: cover property (!serial_q ##1 active_slot[2]);
   c_addr_nack: cover property (take && req_kind == REQ_ADDR && !addr_hit);

endmodule // scp_config_port
`default_nettype wire

// >>> common/scp_pkg.sv
package scp_pkg;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int unsigned CLK_SYS_MHZ = 50;
   localparam int unsigned NVM_WRITE_TIME_US = 10_000;
   localparam int unsigned NVM_WRITE_CYCLES_DEF =
      NVM_WRITE_TIME_US * CLK_SYS_MHZ;

   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam int unsigned REG_BYTES = 32;
   localparam logic [4:0] IDX_IDENT = 5'h00;
   localparam logic [4:0] IDX_DEV_CTRL = 5'h01;
   localparam logic [4:0] IDX_PIN_CFG = 5'h02;
   localparam logic [4:0] IDX_Y1_SLOTS = 5'h04;
   localparam logic [4:0] IDX_BLK_CTRL = 5'h06;
   localparam logic [4:0] IDX_SPREAD_LO = 5'h10;
   localparam logic [4:0] IDX_SPREAD_MID = 5'h11;
   localparam logic [4:0] IDX_SPREAD_HI = 5'h12;
   localparam logic [4:0] IDX_FREQ_SLOTS = 5'h13;
   localparam logic [4:0] IDX_PAIR_SLOTS = 5'h15;
   localparam int unsigned BIT_NVM_BUSY = 6;
   localparam int unsigned BIT_POWER_DOWN = 4;
   localparam int unsigned BIT_PIN_FUNC = 6;
   localparam int unsigned BIT_NVM_GO = 0;
   localparam logic [7:0] DEV_CTRL_MASK = 8'h3f;
   localparam logic [7:0] BLK_CTRL_MASK = 8'hfe;
   localparam logic [7:0] SLOT_DEF = 8'h02;
   localparam logic [7:0] BLK_CTRL_DEF = 8'h80;

   // ----------------------------------------
   // serial address and byte framing
   // ----------------------------------------
   localparam logic [4:0] ADDR_FIXED = 5'h19;
   localparam logic [1:0] ADDR_LSB_DEF = 2'h1;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] LAST_BIT = 4'h7;

   typedef enum logic [1:0] {
      REQ_ADDR, REQ_WRITE, REQ_RD_ONE, REQ_RD_BLK
   } scp_req_type;

   // factory default image of the register file
   function automatic logic [7:0] scp_reset_byte(input logic [4:0] idx);
      unique case (idx)
         IDX_DEV_CTRL: scp_reset_byte = {6'h00, ADDR_LSB_DEF};
         IDX_Y1_SLOTS: scp_reset_byte = SLOT_DEF;
         IDX_PAIR_SLOTS: scp_reset_byte = SLOT_DEF;
         IDX_BLK_CTRL: scp_reset_byte = BLK_CTRL_DEF;
         default: scp_reset_byte = 8'h00;
      endcase
   endfunction

endpackage

// >>> rtl/scp_link_engine.sv
`timescale 1ns/1ps
`default_nettype none
module scp_link_engine
   import scp_pkg::*;
(
   input wire logic clk_link,
   input wire logic rst_link_n,
   input wire logic scl_pin,
   input wire logic sda_pin,
   input wire logic ack_tgl,
   input wire logic rsp_ok,
   input wire logic [7:0] rsp_data,
   output logic sda_low,
   output logic req_tgl,
   output scp_req_type req_kind,
   output logic [6:0] req_off,
   output logic [7:0] req_data
);
   typedef enum {
      LK_IDLE, LK_RX, LK_WAIT, LK_ACK, LK_TX, LK_TX_ACK, LK_IGNORE
   } scp_lk_state_type;
   typedef enum {PH_ADDR, PH_CMD, PH_DATA, PH_READ} scp_phase_type;

   scp_lk_state_type st_q;
   scp_phase_type ph_q;
   logic [1:0] scl_s_q, sda_s_q, ack_s_q;
   logic scl_d_q, sda_d_q, blk_q;
   logic [7:0] sh_q, ord_q;
   logic [3:0] cnt_q;
   logic [6:0] off_q;
   logic scl, sda, scl_rise, scl_fall, start, stop;

   // ----------------------------------------
   // pin synchronisers and bus events
   // ----------------------------------------
   always_ff @(posedge clk_link) begin
      scl_s_q <= {scl_s_q[0], scl_pin};
      sda_s_q <= {sda_s_q[0], sda_pin};
      ack_s_q <= {ack_s_q[0], ack_tgl};
      scl_d_q <= scl_s_q[1];
      sda_d_q <= sda_s_q[1];
   end

   assign scl = scl_s_q[1];
   assign sda = sda_s_q[1];
   assign scl_rise = scl & ~scl_d_q;
   assign scl_fall = ~scl & scl_d_q;
   assign start = scl & scl_d_q & ~sda & sda_d_q;
   assign stop = scl & scl_d_q & sda & ~sda_d_q;

   // ----------------------------------------
   // byte engine, msb first
   // ----------------------------------------
   always_ff @(posedge clk_link) begin
      if (!rst_link_n) begin
         st_q <= LK_IDLE;
         ph_q <= PH_ADDR;
         sh_q <= 8'h00;
         cnt_q <= 4'h0;
         blk_q <= 1'b0;
         off_q <= 7'h00;
         ord_q <= 8'h00;
         sda_low <= 1'b0;
         req_tgl <= 1'b0;
         req_kind <= REQ_ADDR;
         req_off <= 7'h00;
         req_data <= 8'h00;
      end else if (start) begin
         st_q <= LK_RX;
         ph_q <= PH_ADDR;
         cnt_q <= 4'h0;
         sda_low <= 1'b0;
      end else if (stop) begin
         st_q <= LK_IDLE;
         sda_low <= 1'b0;
      end else begin
         unique case (st_q)
            LK_RX: begin
               if (scl_rise) begin
                  sh_q <= {sh_q[6:0], sda};
                  cnt_q <= cnt_q + 4'h1;
               end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
                  cnt_q <= 4'h0;
                  if (ph_q == PH_ADDR) begin
                     req_tgl <= ~req_tgl;
                     req_kind <= REQ_ADDR;
                     req_data <= sh_q; // rw in bit 0
                     st_q <= LK_WAIT;
                  end else if (ph_q == PH_CMD) begin
                     off_q <= sh_q[6:0];
                     blk_q <= ~sh_q[7];
                     ord_q <= 8'h00;
                     ph_q <= PH_DATA;
                     sda_low <= 1'b1;
                     st_q <= LK_ACK;
                  end else if (!blk_q && ord_q != 8'h00) begin
                     st_q <= LK_IGNORE; // single byte only
                  end else begin
                     req_tgl <= ~req_tgl;
                     req_kind <= REQ_WRITE;
                     req_off <= off_q;
                     req_data <= sh_q;
                     st_q <= LK_WAIT;
                  end
               end
            end
            LK_WAIT: begin
               if (ack_s_q[1] == req_tgl) begin
                  if (!rsp_ok) begin
                     st_q <= LK_IGNORE; // data stays released
                  end else if (ph_q == PH_ADDR) begin
                     ph_q <= req_data[0] ? PH_READ : PH_CMD;
                     ord_q <= 8'h00;
                     sda_low <= 1'b1;
                     st_q <= LK_ACK;
                  end else if (ph_q == PH_DATA) begin
                     ord_q <= ord_q + 8'h01;
                     if (blk_q) off_q <= off_q + 7'h01;
                     sda_low <= 1'b1;
                     st_q <= LK_ACK;
                  end else begin
                     sh_q <= rsp_data;
                     sda_low <= ~rsp_data[7];
                     cnt_q <= 4'h0;
                     st_q <= LK_TX;
                  end
               end
            end
            LK_ACK: begin
               if (scl_fall) begin
                  sda_low <= 1'b0;
                  if (ph_q == PH_READ) begin
                     req_tgl <= ~req_tgl;
                     req_kind <= blk_q ? REQ_RD_BLK : REQ_RD_ONE;
                     req_off <= off_q;
                     req_data <= ord_q;
                     st_q <= LK_WAIT;
                  end else begin
                     st_q <= LK_RX;
                  end
               end
            end
            LK_TX: begin
               if (scl_fall) begin
                  if (cnt_q == LAST_BIT) begin
                     sda_low <= 1'b0;
                     st_q <= LK_TX_ACK;
                  end else begin
                     sh_q <= {sh_q[6:0], 1'b0};
                     sda_low <= ~sh_q[6];
                     cnt_q <= cnt_q + 4'h1;
                  end
               end
            end
            LK_TX_ACK: begin
               if (scl_rise) begin
                  if (sda) begin
                     st_q <= LK_IGNORE;
                  end else begin
                     ord_q <= ord_q + 8'h01;
                     if (blk_q) off_q <= off_q + 7'h01;
                     st_q <= LK_ACK;
                  end
               end
            end
            default: sda_low <= 1'b0;
         endcase
      end
   end

endmodule // scp_link_engine
`default_nettype wire

// >>> testbench/scp_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// two-wire bus master model
// ----------------------------------------
module scp_bus_master (
   input wire logic clk_sys,
   input wire logic sda_line,
   output logic scl_o,
   output logic sda_low
);
   // both lines released at start, pull-up holds them high
   initial begin
      scl_o = 1'b1;
      sda_low = 1'b0;
   end
   // quarter bit, launched a fixed delay after an edge
   task automatic q();
      repeat (20) @(posedge clk_sys);
      #2;
   endtask
   // start or repeated start, data falls while clock high
   task automatic start();
      sda_low = 1'b0;
      q();
      scl_o = 1'b1;
      q();
      sda_low = 1'b1;
      q();
      scl_o = 1'b0;
      q();
   endtask
   task automatic stop();
      sda_low = 1'b1;
      q();
      scl_o = 1'b1;
      q();
      sda_low = 1'b0;
      q();
   endtask
   // one bit: drive, raise clock, sample while high, drop clock
   task automatic bit_io(input logic b, output logic r);
      sda_low = !b;
      q();
      scl_o = 1'b1;
      q();
      r = sda_line;
      q();
      scl_o = 1'b0;
      q();
   endtask
   // msb first, ninth clock samples acknowledge
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask
   // master acknowledges every byte but the last of a read
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(last, r);
   endtask
   // shared pins used as plain levels in control mode
   task automatic pins(input logic c, input logic d);
      scl_o = c;
      sda_low = !d;
      q();
   endtask
endmodule // scp_bus_master
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import scp_pkg::*;
   logic clk_sys, clk_link, reset_n, first_pin, rail_gnd, busy, k;
   logic sda_out, sda_oe, serial_port_active, nvm_flag, dev_pd;
   logic first_out, freq_sel, pair_sel, scl_o, sda_low;
   logic [2:0] active_slot, spread;
   logic [7:0] mdl [32];
   logic [7:0] wbuf [16];
   logic [8:0] seen_v;
   logic [8:0] exp_q [$];
   string nam_q [$];
   event seen_ev;
   int failures, comparisons, cyc;
   wire sda_line = !(sda_oe || sda_low);
   scp_config_port #(.NVM_WRITE_CYCLES(12000), .IDENT_BYTE(8'h3c))
   i_scp_config_port (.clk_sys(clk_sys), .reset_n(reset_n),
      .clk_link(clk_link), .sda_in(sda_line), .sda_out(sda_out),
      .sda_oe(sda_oe), .scl_in(scl_o), .first_select_pin(first_pin),
      .output_supply_rail_grounded(rail_gnd), .active_slot(active_slot),
      .first_output_state_select(first_out),
      .frequency_slot_select(freq_sel), .spread_amount_select(spread),
      .pll_output_pair_state_select(pair_sel),
      .device_power_down(dev_pd), .nvm_programming_busy_flag(nvm_flag),
      .serial_port_active(serial_port_active));
   scp_bus_master i_scp_bus_master (.clk_sys(clk_sys),
      .sda_line(sda_line), .scl_o(scl_o), .sda_low(sda_low));
   // clocks, link clock unrelated in phase
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = !clk_sys;
   end
   initial begin
      clk_link = 1'b0;
      #7;
      forever #16 clk_link = !clk_link;
   end
   task automatic final_report();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // hang guard
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 90000) begin
         failures++;
         final_report();
      end
   end
   task automatic check(string n, logic [8:0] s, logic [8:0] e);
      comparisons++;
      if (s !== e) begin
         failures++;
         $display("CHECK FAILED %s exp %h seen %h", n, e, s);
      end
   endtask
   // driver side notes expectation, watcher compares
   task automatic note(string n, logic [8:0] e, logic [8:0] s);
      nam_q.push_back(n);
      exp_q.push_back(e);
      seen_v = s;
      ->seen_ev;
      #1;
   endtask
   initial forever begin
      @(seen_ev);
      check(nam_q.pop_front(), seen_v, exp_q.pop_front());
   end
   task automatic tick(int n);
      repeat (n) @(posedge clk_sys);
      #2;
   endtask
   function automatic logic [7:0] rexp(logic [6:0] o);
      if (o == 7'h00) return 8'h3c;
      if (o == 7'h01) return {1'b0, busy, mdl[1][5:0]};
      return mdl[o[4:0]];
   endfunction
   task automatic outs(logic [2:0] s);
      tick(6);
      note("active slot", 9'(s), 9'(active_slot));
      note("slot outputs", {2'b00, mdl[1][4], mdl[4][s], mdl[19][s],
         mdl[18][s], mdl[17][s], mdl[16][s], mdl[21][s]},
         {2'b00, dev_pd, first_out, freq_sel, spread, pair_sel});
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] c, int n, logic ea, ed);
      i_scp_bus_master.start();
      i_scp_bus_master.wbyte(a, k);
      note("addr ack", 9'(ea), 9'(k));
      if (k) begin
         i_scp_bus_master.wbyte(c, k);
         note("cmd ack", 9'h001, 9'(k));
         for (int i = 0; i < n; i++) begin
            i_scp_bus_master.wbyte(wbuf[i], k);
            note("data ack", 9'(ed), 9'(k));
            if (ed) mdl[5'(c[6:0] + 7'(i))] = wbuf[i];
         end
      end
      i_scp_bus_master.stop();
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] c, int n);
      logic [7:0] d;
      i_scp_bus_master.start();
      i_scp_bus_master.wbyte(a, k);
      i_scp_bus_master.wbyte(c, k);
      i_scp_bus_master.start();
      i_scp_bus_master.wbyte(a | 8'h01, k);
      note("read addr ack", 9'h001, 9'(k));
      for (int i = 0; i < n; i++) begin
         i_scp_bus_master.rbyte(i == n - 1, d);
         note("read byte", 9'(rexp(c[6:0] + 7'(i))), 9'(d));
      end
      i_scp_bus_master.stop();
   endtask
   // main sequence
   initial begin
      reset_n = 1'b0;
      first_pin = 1'b0;
      rail_gnd = 1'b0;
      busy = 1'b0;
      void'($urandom(4));
      for (int i = 0; i < 32; i++) mdl[i] = 8'h00;
      mdl[1] = 8'h01;
      mdl[4] = 8'h02;
      mdl[6] = 8'h80;
      mdl[21] = 8'h02;
      tick(16);
      reset_n = 1'b1;
      tick(8);
      note("serial active", 9'h001, 9'(serial_port_active));
      outs(3'h0);
      first_pin = 1'b1;
      outs(3'h1);
      wbuf[0] = 8'h03;
      wr(8'hca, 8'h84, 1, 1'b1, 1'b1);
      first_pin = 1'b0;
      outs(3'h0);
      rd(8'hca, 8'h84, 1);
      wr(8'hc8, 8'h84, 1, 1'b0, 1'b0);
      for (int i = 0; i < 4; i++) wbuf[i] = 8'($urandom);
      wr(8'hca, 8'h10, 4, 1'b1, 1'b1);
      first_pin = 1'b1;
      outs(3'h1);
      rd(8'hca, 8'h10, 16);
      rd(8'hca, 8'h80, 1);
      wbuf[0] = 8'h12;
      wr(8'hca, 8'h81, 1, 1'b1, 1'b1);
      wr(8'hca, 8'h81, 0, 1'b0, 1'b0);
      outs(3'h1);
      wbuf[0] = 8'h02;
      wr(8'hcc, 8'h81, 1, 1'b1, 1'b1);
      wbuf[0] = 8'h40;
      wr(8'hcc, 8'h82, 1, 1'b1, 1'b1);
      note("serial active", 9'h001, 9'(serial_port_active));
      wbuf[0] = 8'h81;
      wr(8'hcc, 8'h86, 1, 1'b1, 1'b1);
      mdl[6] = 8'h80;
      busy = 1'b1;
      note("nvm busy", 9'h001, 9'(nvm_flag));
      rd(8'hcc, 8'h81, 1);
      wr(8'hcc, 8'h84, 1, 1'b1, 1'b0);
      for (int i = 0; i < 20000 && nvm_flag === 1'b1; i++) tick(1);
      busy = 1'b0;
      tick(8);
      note("nvm busy", 9'h000, 9'(nvm_flag));
      note("serial active", 9'h000, 9'(serial_port_active));
      wr(8'hcc, 8'h84, 0, 1'b0, 1'b0);
      rail_gnd = 1'b1;
      tick(8);
      note("serial active", 9'h001, 9'(serial_port_active));
      wr(8'hcc, 8'h84, 0, 1'b1, 1'b1);
      rail_gnd = 1'b0;
      i_scp_bus_master.pins(1'b0, 1'b1);
      outs(3'h3);
      i_scp_bus_master.pins(1'b1, 1'b0);
      outs(3'h5);
      final_report();
   end
endmodule // tb_top
`default_nettype wire
